// *** design/octsc_pkg.sv ***
package octsc_pkg;
  // core clock rate
  localparam int CLK_MHZ = 250;

  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register byte offsets
  localparam logic [7:0] REG_TUNE = 8'h00;
  localparam logic [7:0] REG_SPREAD = 8'h04;
  localparam logic [7:0] REG_EXT = 8'h08;
  localparam logic [7:0] REG_OUTSEL = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // field positions
  localparam int SPREAD_EN_BIT = 0;
  localparam int SPREAD_CAR_BIT = 1;
  localparam int EXT_DIV_BIT = 0;
  localparam int EXT_ROUTE_BIT = 1;
  localparam int OUT_PICK_BIT = 4;
  localparam int ST_RANGE_BIT = 0;
  localparam int ST_ROUTED_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_SETTLE_BIT = 3;

  // values after reset
  localparam logic [3:0] TUNE_RESET = 4'h0;
  localparam logic [3:0] OUTSEL_RESET = 4'h0;

  // tuning codes of the defined set
  localparam logic [3:0] TUNE_UP_MAX = 4'h4;
  localparam logic [3:0] TUNE_DN_MIN = 4'h9;
  localparam logic [3:0] TUNE_DN_MAX = 4'hc;

  // sync output select codes
  localparam logic [3:0] OSEL_PREREG = 4'h1;
  localparam logic [3:0] OSEL_CORE_BUCK = 4'h3;
  localparam logic [3:0] OSEL_AUX_BUCK = 4'h5;
  localparam logic [3:0] OSEL_SWITCH = 4'h6;
  localparam logic [3:0] OSEL_MAIN_DIV = 4'h7;
  localparam logic [3:0] OSEL_FS_DIV = 4'h8;
  localparam logic [3:0] OSEL_EXT_DIV = 4'h9;

  // switching clock rates and half periods in core cycles
  localparam int FAST_KHZ = 2220;
  localparam int SLOW_KHZ = 455;
  localparam int FAST_HALF = CLK_MHZ * 1000 / (2 * FAST_KHZ);
  localparam int SLOW_HALF = CLK_MHZ * 1000 / (2 * SLOW_KHZ);

  // oscillator monitor dividers in input edges per period, and their half periods
  localparam int OSC_DIV = 48;
  localparam int OSC_HALF = OSC_DIV / 2;
  localparam int EXT_PRE_DIV = 6;
  localparam int EXT_HALF = EXT_PRE_DIV / 2;

  // divided external clock period window, in ns and cycles
  localparam int EXT_MIN_NS = 2000;
  localparam int EXT_LOST_NS = 3000;
  localparam int SYNC_LAT = 4;
  localparam int EXT_MIN_CYC = EXT_MIN_NS * CLK_MHZ / 1000;
  localparam int EXT_LOST_CYC = EXT_LOST_NS * CLK_MHZ / 1000 - SYNC_LAT;

  // pll lock and settle times in us
  localparam int LOCK_US = 90;
  localparam int SETTLE_US = 125;

  // spread spectrum: deviation in 0.1 percent units, triangle steps
  localparam int SPREAD_DEV = 50;
  localparam int SPREAD_STEPS = 4 * SPREAD_DEV;
  localparam int CAR_SLOW_HZ = 23000;
  localparam int CAR_FAST_HZ = 94000;
  localparam int STEP_SLOW =
    CLK_MHZ * 1000000 / CAR_SLOW_HZ / SPREAD_STEPS;
  localparam int STEP_FAST =
    CLK_MHZ * 1000000 / CAR_FAST_HZ / SPREAD_STEPS;

  // external route sequencer
  typedef enum logic [1:0] {
    ROUTE_IDLE,
    ROUTE_LOCK,
    ROUTE_EXT
  } octsc_route_t;
endpackage

// *** design/octsc_ext_monitor.sv ***
`timescale 1ns/1ps
module octsc_ext_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic syncClockIn,
  input wire logic dividerSelect,
  output logic dividedExtClock,
  output logic extClockInRange
);
  logic sync1_reg, sync2_reg, prev_reg;
  logic [1:0] edgeCnt_reg, edgeCnt_next;
  logic divClk_reg, divClk_next, divPrev_reg;
  logic [9:0] perCnt_reg, perCnt_next;
  logic inRange_reg, inRange_next;
  logic inEdge, divEdge;

  // edge of the pin after two flops, and of the divided clock
  assign inEdge = sync2_reg & ~prev_reg;
  assign divEdge = divClk_reg & ~divPrev_reg;

  // input divider and period watchdog
  always_comb begin
    edgeCnt_next = edgeCnt_reg;
    divClk_next = divClk_reg;
    perCnt_next = perCnt_reg;
    inRange_next = inRange_reg;
    if (!dividerSelect) begin
      divClk_next = sync2_reg;
      edgeCnt_next = 2'h0;
    end else if (inEdge) begin
      if (edgeCnt_reg == 2'(octsc_pkg::EXT_HALF - 1)) begin
        edgeCnt_next = 2'h0;
        divClk_next = ~divClk_reg;
      end else begin
        edgeCnt_next = edgeCnt_reg + 2'h1;
      end
    end
    if (divEdge) begin
      perCnt_next = 10'h000;
      // short deviation: period below the window fails at once
      inRange_next = (perCnt_reg >= 10'(octsc_pkg::EXT_MIN_CYC));
    end else if (perCnt_reg >= 10'(octsc_pkg::EXT_LOST_CYC)) begin
      inRange_next = 1'b0; // long period or lost input
    end else begin
      perCnt_next = perCnt_reg + 10'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      edgeCnt_reg <= 2'h0;
      divClk_reg <= 1'b0;
      divPrev_reg <= 1'b0;
      perCnt_reg <= 10'h000;
      inRange_reg <= 1'b0;
    end else begin
      sync1_reg <= syncClockIn;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      edgeCnt_reg <= edgeCnt_next;
      divClk_reg <= divClk_next;
      divPrev_reg <= divClk_reg;
      perCnt_reg <= perCnt_next;
      inRange_reg <= inRange_next;
    end
  end

  assign dividedExtClock = divClk_reg;
  assign extClockInRange = inRange_reg;
endmodule

// *** design/octsc_clock_ctrl.sv ***
`timescale 1ns/1ps
module octsc_clock_ctrl #(
  parameter int LOCK_CYCLES = octsc_pkg::LOCK_US * octsc_pkg::CLK_MHZ,
  parameter int SETTLE_CYCLES = octsc_pkg::SETTLE_US * octsc_pkg::CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic mainOscillator,
  input wire logic failsafeOscillator,
  input wire logic syncClockIn,
  input wire logic pllFuseEnable,
  input wire logic preregSlowSelect,
  output logic [3:0] oscTuneCode,
  output logic spreadActive,
  output logic [6:0] spreadOffset,
  output logic preregulatorClock,
  output logic coreBuckClock,
  output logic auxBuckClock,
  output logic pllInputEnable,
  output logic extRouteActive,
  output logic syncClockOut
);
  // half-period toggler shared by the switching and oscillator dividers
  function automatic logic [8:0] divCount(input logic [8:0] cnt,
                                          input int half);
    divCount = (cnt >= 9'(half - 1)) ? 9'h000 : cnt + 9'h001;
  endfunction

  // defined tuning codes, anything else maps to the 20 MHz code
  function automatic logic [3:0] tuneMap(input logic [3:0] code);
    if (code <= octsc_pkg::TUNE_UP_MAX) begin
      tuneMap = code;
    end else if (code >= octsc_pkg::TUNE_DN_MIN &&
                 code <= octsc_pkg::TUNE_DN_MAX) begin
      tuneMap = code;
    end else begin
      tuneMap = octsc_pkg::TUNE_RESET;
    end
  endfunction

  logic [3:0] tune_reg, tune_next, tuneEff_reg, tuneEff_next;
  logic spreadEn_reg, spreadEn_next, carrier_reg, carrier_next;
  logic extDiv_reg, extDiv_next, routeBit_reg, routeBit_next;
  logic [3:0] outSel_reg, outSel_next;
  logic outPick_reg, outPick_next;
  logic [7:0] rdData_reg, rdData_next;
  logic [6:0] offset_reg, offset_next;
  logic spreadUp_reg, spreadUp_next;
  logic [5:0] stepCnt_reg, stepCnt_next;
  logic [8:0] fastCnt_reg, fastCnt_next, slowCnt_reg, slowCnt_next;
  logic fastClk_reg, fastClk_next, slowClk_reg, slowClk_next;
  logic prereg_reg, prereg_next, coreBuck_reg, auxBuck_reg;
  logic mainS1_reg, mainS2_reg, mainPrev_reg;
  logic fsS1_reg, fsS2_reg, fsPrev_reg;
  logic [8:0] mainCnt_reg, mainCnt_next, fsCnt_reg, fsCnt_next;
  logic mainDiv_reg, mainDiv_next, fsDiv_reg, fsDiv_next;
  octsc_pkg::octsc_route_t route_reg, route_next;
  logic [15:0] lockCnt_reg, lockCnt_next;
  logic locked_reg, locked_next, settled_reg, settled_next;
  logic pllIn_reg, pllIn_next, extAct_reg, extAct_next;
  logic syncOut_reg, syncOut_next;
  logic dividedExtClock, extClockInRange;
  logic [5:0] stepLimit;

  // divider and watchdog of the sync input
  octsc_ext_monitor u_monitor (
    .core_clk(core_clk),
    .reset(reset),
    .syncClockIn(syncClockIn),
    .dividerSelect(extDiv_reg),
    .dividedExtClock(dividedExtClock),
    .extClockInRange(extClockInRange)
  );

  // register writes, readback and tuning code
  always_comb begin
    tune_next = tune_reg;
    spreadEn_next = spreadEn_reg;
    carrier_next = carrier_reg;
    extDiv_next = extDiv_reg;
    routeBit_next = routeBit_reg;
    outSel_next = outSel_reg;
    outPick_next = outPick_reg;
    rdData_next = 8'h00;
    if (regWrEn) begin
      unique case (regAddr)
        octsc_pkg::REG_TUNE: tune_next = regWrData[3:0];
        octsc_pkg::REG_SPREAD: begin
          spreadEn_next = regWrData[octsc_pkg::SPREAD_EN_BIT];
          carrier_next = regWrData[octsc_pkg::SPREAD_CAR_BIT];
        end
        octsc_pkg::REG_EXT: begin
          extDiv_next = regWrData[octsc_pkg::EXT_DIV_BIT];
          routeBit_next = regWrData[octsc_pkg::EXT_ROUTE_BIT];
        end
        octsc_pkg::REG_OUTSEL: begin
          outSel_next = regWrData[3:0];
          outPick_next = regWrData[octsc_pkg::OUT_PICK_BIT];
        end
        default: ;
      endcase
    end
    // loss of the input drops the route bit; host must redo it
    if (routeBit_reg && route_reg != octsc_pkg::ROUTE_IDLE &&
        !extClockInRange) begin
      routeBit_next = 1'b0;
    end
    if (regRdEn) begin
      unique case (regAddr)
        octsc_pkg::REG_TUNE: rdData_next = {4'h0, tune_reg};
        octsc_pkg::REG_SPREAD: rdData_next = {6'h00, carrier_reg,
                                              spreadEn_reg};
        octsc_pkg::REG_EXT: rdData_next = {6'h00, routeBit_reg, extDiv_reg};
        octsc_pkg::REG_OUTSEL: rdData_next = {3'h0, outPick_reg, outSel_reg};
        octsc_pkg::REG_STATUS: begin
          rdData_next[octsc_pkg::ST_RANGE_BIT] = extClockInRange;
          rdData_next[octsc_pkg::ST_ROUTED_BIT] = extAct_reg;
          rdData_next[octsc_pkg::ST_LOCK_BIT] = locked_reg;
          rdData_next[octsc_pkg::ST_SETTLE_BIT] = settled_reg;
        end
        default: rdData_next = 8'h00;
      endcase
    end
    tuneEff_next = tuneMap(tune_next);
  end

  // triangular spread carrier, offset in 0.1 percent units
  assign stepLimit = carrier_reg ? 6'(octsc_pkg::STEP_FAST)
                                 : 6'(octsc_pkg::STEP_SLOW);
  always_comb begin
    offset_next = offset_reg;
    spreadUp_next = spreadUp_reg;
    stepCnt_next = stepCnt_reg;
    if (!spreadEn_reg) begin
      offset_next = 7'h00;
      spreadUp_next = 1'b1;
      stepCnt_next = 6'h00;
    end else if (stepCnt_reg >= stepLimit - 6'h01) begin
      stepCnt_next = 6'h00;
      if (spreadUp_reg) begin
        offset_next = offset_reg + 7'h01;
        if ($signed(offset_reg) >= 7'(octsc_pkg::SPREAD_DEV - 1)) begin
          spreadUp_next = 1'b0;
        end
      end else begin
        offset_next = offset_reg - 7'h01;
        if ($signed(offset_reg) <= 7'(1 - octsc_pkg::SPREAD_DEV)) begin
          spreadUp_next = 1'b1;
        end
      end
    end else begin
      stepCnt_next = stepCnt_reg + 6'h01;
    end
  end

  // switching clocks and oscillator dividers, all at 50 percent duty
  always_comb begin
    fastCnt_next = divCount(fastCnt_reg, octsc_pkg::FAST_HALF);
    slowCnt_next = divCount(slowCnt_reg, octsc_pkg::SLOW_HALF);
    fastClk_next = (fastCnt_reg == 9'(octsc_pkg::FAST_HALF - 1)) ?
                   ~fastClk_reg : fastClk_reg;
    slowClk_next = (slowCnt_reg == 9'(octsc_pkg::SLOW_HALF - 1)) ?
                   ~slowClk_reg : slowClk_reg;
    prereg_next = preregSlowSelect ? slowClk_reg : fastClk_reg;
    mainCnt_next = mainCnt_reg;
    mainDiv_next = mainDiv_reg;
    fsCnt_next = fsCnt_reg;
    fsDiv_next = fsDiv_reg;
    if (mainS2_reg && !mainPrev_reg) begin
      mainCnt_next = divCount(mainCnt_reg, octsc_pkg::OSC_HALF);
      if (mainCnt_reg == 9'(octsc_pkg::OSC_HALF - 1)) begin
        mainDiv_next = ~mainDiv_reg;
      end
    end
    if (fsS2_reg && !fsPrev_reg) begin
      fsCnt_next = divCount(fsCnt_reg, octsc_pkg::OSC_HALF);
      if (fsCnt_reg == 9'(octsc_pkg::OSC_HALF - 1)) begin
        fsDiv_next = ~fsDiv_reg;
      end
    end
  end

  // external route sequencer with lock and settle timers
  always_comb begin
    route_next = route_reg;
    lockCnt_next = lockCnt_reg;
    locked_next = locked_reg;
    settled_next = settled_reg;
    unique case (route_reg)
      octsc_pkg::ROUTE_IDLE: begin
        lockCnt_next = 16'h0000;
        locked_next = 1'b0;
        settled_next = 1'b0;
        // route only with the fuse set and a good input
        if (routeBit_reg && pllFuseEnable && extClockInRange) begin
          route_next = octsc_pkg::ROUTE_LOCK;
        end
      end
      octsc_pkg::ROUTE_LOCK: begin
        lockCnt_next = lockCnt_reg + 16'h0001;
        if (lockCnt_reg >= 16'(LOCK_CYCLES - 1)) begin
          locked_next = 1'b1;
          route_next = octsc_pkg::ROUTE_EXT;
        end
      end
      octsc_pkg::ROUTE_EXT: begin
        if (!settled_reg) begin
          lockCnt_next = lockCnt_reg + 16'h0001;
        end
        if (lockCnt_reg >= 16'(SETTLE_CYCLES - 1)) begin
          settled_next = 1'b1;
        end
      end
    endcase
    if (route_reg != octsc_pkg::ROUTE_IDLE &&
        (!extClockInRange || !routeBit_reg)) begin
      route_next = octsc_pkg::ROUTE_IDLE;
    end
    pllIn_next = (route_next != octsc_pkg::ROUTE_IDLE);
    extAct_next = (route_next == octsc_pkg::ROUTE_EXT);
  end

  // sync output multiplexer
  always_comb begin
    unique case (outSel_reg)
      octsc_pkg::OSEL_PREREG: syncOut_next = prereg_reg;
      octsc_pkg::OSEL_CORE_BUCK: syncOut_next = coreBuck_reg;
      octsc_pkg::OSEL_AUX_BUCK: syncOut_next = auxBuck_reg;
      octsc_pkg::OSEL_SWITCH:
        syncOut_next = outPick_reg ? slowClk_reg : fastClk_reg;
      octsc_pkg::OSEL_MAIN_DIV:
        syncOut_next = pllFuseEnable & mainDiv_reg;
      octsc_pkg::OSEL_FS_DIV: syncOut_next = fsDiv_reg;
      octsc_pkg::OSEL_EXT_DIV: syncOut_next = dividedExtClock;
      default: syncOut_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tune_reg <= octsc_pkg::TUNE_RESET;
      tuneEff_reg <= octsc_pkg::TUNE_RESET;
      spreadEn_reg <= 1'b0;
      carrier_reg <= 1'b0;
      extDiv_reg <= 1'b0;
      routeBit_reg <= 1'b0;
      outSel_reg <= octsc_pkg::OUTSEL_RESET;
      outPick_reg <= 1'b0;
      rdData_reg <= 8'h00;
      offset_reg <= 7'h00;
      spreadUp_reg <= 1'b1;
      stepCnt_reg <= 6'h00;
      fastCnt_reg <= 9'h000;
      slowCnt_reg <= 9'h000;
      fastClk_reg <= 1'b0;
      slowClk_reg <= 1'b0;
      prereg_reg <= 1'b0;
      coreBuck_reg <= 1'b0;
      auxBuck_reg <= 1'b0;
      mainS1_reg <= 1'b0;
      mainS2_reg <= 1'b0;
      mainPrev_reg <= 1'b0;
      fsS1_reg <= 1'b0;
      fsS2_reg <= 1'b0;
      fsPrev_reg <= 1'b0;
      mainCnt_reg <= 9'h000;
      fsCnt_reg <= 9'h000;
      mainDiv_reg <= 1'b0;
      fsDiv_reg <= 1'b0;
      route_reg <= octsc_pkg::ROUTE_IDLE;
      lockCnt_reg <= 16'h0000;
      locked_reg <= 1'b0;
      settled_reg <= 1'b0;
      pllIn_reg <= 1'b0;
      extAct_reg <= 1'b0;
      syncOut_reg <= 1'b0;
    end else begin
      tune_reg <= tune_next;
      tuneEff_reg <= tuneEff_next;
      spreadEn_reg <= spreadEn_next;
      carrier_reg <= carrier_next;
      extDiv_reg <= extDiv_next;
      routeBit_reg <= routeBit_next;
      outSel_reg <= outSel_next;
      outPick_reg <= outPick_next;
      rdData_reg <= rdData_next;
      offset_reg <= offset_next;
      spreadUp_reg <= spreadUp_next;
      stepCnt_reg <= stepCnt_next;
      fastCnt_reg <= fastCnt_next;
      slowCnt_reg <= slowCnt_next;
      fastClk_reg <= fastClk_next;
      slowClk_reg <= slowClk_next;
      prereg_reg <= prereg_next;
      coreBuck_reg <= fastClk_reg; // both bucks on the fast clock
      auxBuck_reg <= fastClk_reg;
      mainS1_reg <= mainOscillator;
      mainS2_reg <= mainS1_reg;
      mainPrev_reg <= mainS2_reg;
      fsS1_reg <= failsafeOscillator;
      fsS2_reg <= fsS1_reg;
      fsPrev_reg <= fsS2_reg;
      mainCnt_reg <= mainCnt_next;
      fsCnt_reg <= fsCnt_next;
      mainDiv_reg <= mainDiv_next;
      fsDiv_reg <= fsDiv_next;
      route_reg <= route_next;
      lockCnt_reg <= lockCnt_next;
      locked_reg <= locked_next;
      settled_reg <= settled_next;
      pllIn_reg <= pllIn_next;
      extAct_reg <= extAct_next;
      syncOut_reg <= syncOut_next;
    end
  end

  // outputs straight from flops
  assign regRdData = rdData_reg;
  assign oscTuneCode = tuneEff_reg;
  assign spreadActive = spreadEn_reg;
  assign spreadOffset = offset_reg;
  assign preregulatorClock = prereg_reg;
  assign coreBuckClock = coreBuck_reg;
  assign auxBuckClock = auxBuck_reg;
  assign pllInputEnable = pllIn_reg;
  assign extRouteActive = extAct_reg;
  assign syncClockOut = syncOut_reg;
endmodule

// *** tb/octsc_ext_source.sv ***
`timescale 1ns/1ps
module octsc_ext_source #(
  parameter int FS_HALF_NS = 26
) (
  input wire logic run,
  input wire logic [15:0] halfNs,
  output logic syncClockIn,
  output logic mainOscillator,
  output logic failsafeOscillator
);
  // oscillator pins: main at 20 MHz, fail-safe at a plain default rate
  initial begin
    mainOscillator = 1'h0;
    failsafeOscillator = 1'h0;
  end
  always #25 mainOscillator = ~mainOscillator;
  always #(FS_HALF_NS) failsafeOscillator = ~failsafeOscillator;
  // sync source at even duty; the source drives it low when stopped
  always begin
    if (run) begin
      syncClockIn = 1'h1;
      #(halfNs);
      syncClockIn = 1'h0;
      #(halfNs);
    end else begin
      syncClockIn = 1'h0;
      #7;
    end
  end
endmodule

// *** tb/octsc_clock_ctrl_asserts.sv ***
`timescale 1ns/1ps
module octsc_clock_ctrl_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic syncClockIn,
  input wire logic pllFuseEnable,
  input wire logic [3:0] oscTuneCode,
  input wire logic spreadActive,
  input wire logic [6:0] spreadOffset,
  input wire logic pllInputEnable,
  input wire logic extRouteActive,
  input wire logic syncClockOut
);
  localparam int LOST_MAX = 756;
  logic [3:0] sel_reg, sel_next;
  logic [1:0] pin_reg, pin_next;
  logic [10:0] quiet_reg, quiet_next;
  logic selLow, tuneWr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  function automatic logic defCode(input logic [3:0] c);
    return c <= octsc_pkg::TUNE_UP_MAX ||
      (c >= octsc_pkg::TUNE_DN_MIN && c <= octsc_pkg::TUNE_DN_MAX);
  endfunction
  // shadow output select and cycles since the last sync input edge
  always_comb begin
    sel_next = sel_reg;
    if (regWrEn && regAddr == octsc_pkg::REG_OUTSEL)
      sel_next = regWrData[3:0];
    pin_next = {pin_reg[0], syncClockIn};
    quiet_next = quiet_reg + {10'h000, ~&quiet_reg};
    if (pin_reg == 2'h1) quiet_next = 11'h000;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sel_reg <= 4'h0;
      pin_reg <= 2'h0;
      quiet_reg <= 11'h000;
    end else begin
      sel_reg <= sel_next;
      pin_reg <= pin_next;
      quiet_reg <= quiet_next;
    end
  end
  assign selLow = sel_reg inside {4'h0, 4'h2, 4'h4} || sel_reg > 4'h9;
  assign tuneWr = regWrEn && regAddr == octsc_pkg::REG_TUNE;
  a_tune_apply: assert property (
    tuneWr && defCode(regWrData[3:0]) |=> oscTuneCode == $past(regWrData[3:0]))
    else $error("tune code not applied");
  a_tune_default: assert property (
    tuneWr && !defCode(regWrData[3:0]) |=> oscTuneCode == 4'h0)
    else $error("undefined tune code not at default");
  a_tune_range: assert property (defCode(oscTuneCode))
    else $error("tune code outside the defined set");
  a_spread_span: assert property (
    $signed(spreadOffset) >= -7'sd50 && $signed(spreadOffset) <= 7'sd50)
    else $error("spread offset beyond five percent");
  a_spread_step: assert property (
    spreadActive && $past(spreadActive) |-> spreadOffset == $past(spreadOffset)
    || spreadOffset - $past(spreadOffset) inside {7'h01, 7'h7f})
    else $error("spread offset jumped");
  a_out_silent: assert property (
    selLow && $past(selLow) && $past(selLow, 2) |-> !syncClockOut)
    else $error("sync output active on a silent code");
  a_pll_fuse: assert property ($rose(pllInputEnable) |-> pllFuseEnable)
    else $error("pll started without fuse");
  a_route_lock: assert property (
    $rose(extRouteActive) |-> pllInputEnable && $past(pllInputEnable, 2))
    else $error("route active without lock phase");
  a_lost_fallback: assert property (
    extRouteActive |-> quiet_reg < LOST_MAX)
    else $error("route kept after sync input lost");
  c_route_on: cover property ($rose(extRouteActive));
  c_route_off: cover property ($fell(extRouteActive));
  c_spread_peak: cover property (spreadActive && spreadOffset == 7'h32);
endmodule
bind octsc_clock_ctrl octsc_clock_ctrl_asserts u_asserts (
  .core_clk(core_clk), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .syncClockIn(syncClockIn),
  .pllFuseEnable(pllFuseEnable), .oscTuneCode(oscTuneCode),
  .spreadActive(spreadActive), .spreadOffset(spreadOffset),
  .pllInputEnable(pllInputEnable), .extRouteActive(extRouteActive),
  .syncClockOut(syncClockOut));

// *** tb/osc_tune_spread_sync_ctrl_test.sv ***
`timescale 1ns/1ps
module osc_tune_spread_sync_ctrl_test;
  localparam int LOCK = 200;
  localparam int SETTLE = 300;
  localparam int FAST = octsc_pkg::FAST_HALF;
  localparam int SLOW = octsc_pkg::SLOW_HALF;
  localparam logic [7:0] A_EXT = octsc_pkg::REG_EXT;
  localparam logic [7:0] A_STAT = octsc_pkg::REG_STATUS;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'h0;
  logic regRdEn = 1'h0;
  logic pllFuseEnable = 1'h0;
  logic preregSlowSelect = 1'h0;
  logic run = 1'h0;
  logic [15:0] halfNs = 16'h00c8;
  logic [7:0] regRdData, v;
  logic mainOscillator, failsafeOscillator, syncClockIn, spreadActive;
  logic preregulatorClock, coreBuckClock, auxBuckClock, pllInputEnable;
  logic extRouteActive, syncClockOut;
  logic [3:0] oscTuneCode;
  logic [6:0] spreadOffset;
  logic [31:0] lfsr = 32'h395e;
  logic [7:0] regs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [3:0] und [7] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hd, 4'he, 4'hf};
  logic [3:0] walk [19] = '{4'h5, 4'hf, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
    4'h3, 4'h2, 4'h1, 4'h0, 4'hc, 4'hb, 4'ha, 4'h9, 4'ha, 4'hb, 4'hc, 4'h0};
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int t, h, n, e;
  octsc_ext_source src (.run(run), .halfNs(halfNs), .syncClockIn(syncClockIn),
    .mainOscillator(mainOscillator), .failsafeOscillator(failsafeOscillator));
  octsc_clock_ctrl #(.LOCK_CYCLES(LOCK), .SETTLE_CYCLES(SETTLE)) DUT (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .mainOscillator(mainOscillator),
    .failsafeOscillator(failsafeOscillator), .syncClockIn(syncClockIn),
    .pllFuseEnable(pllFuseEnable), .preregSlowSelect(preregSlowSelect),
    .oscTuneCode(oscTuneCode), .spreadActive(spreadActive),
    .spreadOffset(spreadOffset), .preregulatorClock(preregulatorClock),
    .coreBuckClock(coreBuckClock), .auxBuckClock(auxBuckClock),
    .pllInputEnable(pllInputEnable), .extRouteActive(extRouteActive),
    .syncClockOut(syncClockOut));
  // core clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_errors++;
      finish_test();
    end
  end
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] expTune(input logic [3:0] c);
    return (c <= 4'h4 || (c >= 4'h9 && c <= 4'hc)) ? c : 4'h0;
  endfunction
  // expected half period in core cycles of the sync output, 0 when silent
  function automatic int expHalf(input logic [3:0] c, input logic pk);
    case (c)
      4'h1: return preregSlowSelect ? SLOW : FAST;
      4'h3, 4'h5: return FAST;
      4'h6: return pk ? SLOW : FAST;
      4'h7, 4'h9: return 300;
      4'h8: return 312;
      default: return 0;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'h1;
    @(posedge core_clk);
    regWrEn <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge core_clk);
    regRdEn <= 1'h0;
    #1 v = regRdData;
  endtask
  // cycles until the spread offset reaches a value, or until route drops
  task automatic waitFor(input logic spr, input logic [6:0] tgt);
    t = 0;
    while ((spr ? spreadOffset !== tgt : extRouteActive === 1'h1)
      && t < 12000) begin
      @(posedge core_clk);
      #1 t++;
    end
  endtask
  task automatic routeOn;
    wr(A_EXT, 8'h03);
    repeat (2) @(posedge core_clk);
    #1 check({pllInputEnable, extRouteActive}, 2'h2);
    repeat (LOCK) @(posedge core_clk);
    #1 check(extRouteActive, 1'h1);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'h0;
    foreach (regs[i]) begin
      rd(regs[i]);
      check(v, 8'h00);
    end
    lfsr = nextRand(lfsr);
    wr(8'h80 | lfsr[7:0], 8'hff);
    rd(8'h80 | lfsr[7:0]);
    check({v, oscTuneCode, spreadActive, syncClockOut}, 14'h0000);
    walk[2] = und[lfsr % 7];
    foreach (walk[i]) begin
      wr(8'h00, {4'h0, walk[i]});
      @(posedge core_clk);
      #1 check(oscTuneCode, expTune(walk[i]));
      rd(8'h00);
      check(v, {4'h0, walk[i]});
      repeat (10 * octsc_pkg::CLK_MHZ) @(posedge core_clk);
    end
    for (int car = 0; car < 2; car++) begin
      preregSlowSelect <= !car[0];
      wr(8'h04, {6'h00, car[0], 1'h1});
      @(posedge core_clk);
      #1 check(spreadActive, 1'h1);
      waitFor(1'h1, 7'h32);
      waitFor(1'h1, 7'h4e);
      e = octsc_pkg::CLK_MHZ * 500000 /
        (car ? octsc_pkg::CAR_FAST_HZ : octsc_pkg::CAR_SLOW_HZ);
      check(t * 100 >= e * 97 && t * 100 <= e * 103, 1'h1);
      wr(8'h04, 8'h00);
    end
    for (int d = 0; d < 2; d++) begin
      wr(A_EXT, {7'h00, d[0]});
      halfNs <= d ? 16'h00c8 : 16'h04b0;
      run <= 1'h1;
      repeat (2000) @(posedge core_clk);
      rd(A_STAT);
      check(v[0], 1'h1);
    end
    wr(A_EXT, 8'h03);
    repeat (10) @(posedge core_clk);
    #1 check(pllInputEnable, 1'h0);
    wr(A_EXT, 8'h01);
    pllFuseEnable <= 1'h1;
    routeOn();
    rd(A_STAT);
    check(v, 8'h07);
    repeat (SETTLE - LOCK) @(posedge core_clk);
    rd(A_STAT);
    check(v, 8'h0f);
    run <= 1'h0;
    waitFor(1'h0, 7'h00);
    check(t <= 756, 1'h1);
    rd(A_STAT);
    check(v[1:0], 2'h0);
    rd(A_EXT);
    check(v, 8'h01);
    run <= 1'h1;
    repeat (2000) @(posedge core_clk);
    routeOn();
    halfNs <= 16'h0064;
    waitFor(1'h0, 7'h00);
    check(t <= 1250, 1'h1);
    halfNs <= 16'h00c8;
    repeat (2000) @(posedge core_clk);
    for (int c = 0; c < 16; c++) begin
      lfsr = nextRand(lfsr);
      preregSlowSelect <= lfsr[0];
      wr(8'h0c, {3'h0, lfsr[1], c[3:0]});
      repeat (8) @(posedge core_clk);
      h = expHalf(c[3:0], lfsr[1]);
      n = 0;
      repeat (800) begin
        @(posedge core_clk);
        #1 v[0] = syncClockOut;
        if (v[0] && !v[1]) n++;
        v[1] = v[0];
        check(auxBuckClock, coreBuckClock);
        if (!preregSlowSelect)
          check(preregulatorClock, coreBuckClock);
      end
      if (h == 0) check(n, 0);
      else check(n >= 400 / h - 1 && n <= 400 / h + 1, 1'h1);
    end
    finish_test();
  end
endmodule
